// [design/mpt_timebase.sv]
// PWM time base counter, postscalers and control register set.
`timescale 1ns/1ps
module mpt_timebase
  import mpt_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pin_default_cfg_i,
  input wire logic sev_match_i,
  input wire logic override_change_i,
  output logic [CNT_W-1:0] timebase_counter_o,
  output logic count_down_flag_o,
  output logic center_aligned_o,
  output logic tb_event_o,
  output logic sev_trig_o,
  output logic update_enable_o,
  output logic override_apply_o,
  output logic [7:0] pin_enable_o,
  output logic [3:0] pair_indep_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic ack_q;
  logic [31:0] dat_q;
  logic [7:0] ctrl_a_q;
  logic run_q;
  mpt_dir_t dir_q;
  logic [2:0] pin_en_q;
  logic [3:0] pair_mode_bits_q;
  logic [3:0] sops_q;
  logic sdir_q;
  logic buffer_update_block_q;
  logic override_sync_sel_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] per_buf_q;
  logic [CNT_W-1:0] per_act_q;
  logic [3:0] post_q;
  logic [3:0] sev_cnt_q;
  logic tb_ev_q;
  logic sev_q;
  logic ovr_pend_q;
  logic ovr_q;
  logic strap_done_q;
  logic [7:0] pins_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic req, wr_go, cnt_wr, presc_clr;
  logic hit_a, hit_b, hit_p, hit_t, hit_c, hit_r;
  logic wr_a, wr_b, wr_p, wr_t, wr_c_lo, wr_c_hi, wr_r_lo, wr_r_hi;
  logic [31:0] rd_mux;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr_go = req & wb_we_i & ack_q;
  assign hit_a = (wb_adr_i == OFS_CTRL_A);
  assign hit_b = (wb_adr_i == OFS_CTRL_B);
  assign hit_p = (wb_adr_i == OFS_PINMODE);
  assign hit_t = (wb_adr_i == OFS_TRIG);
  assign hit_c = (wb_adr_i == OFS_COUNTER);
  assign hit_r = (wb_adr_i == OFS_PERIOD);
  assign wr_a = wr_go & hit_a & wb_sel_i[0];
  assign wr_b = wr_go & hit_b & wb_sel_i[0];
  assign wr_p = wr_go & hit_p & wb_sel_i[0];
  assign wr_t = wr_go & hit_t & wb_sel_i[0];
  assign wr_c_lo = wr_go & hit_c & wb_sel_i[0];
  assign wr_c_hi = wr_go & hit_c & wb_sel_i[1];
  assign wr_r_lo = wr_go & hit_r & wb_sel_i[0];
  assign wr_r_hi = wr_go & hit_r & wb_sel_i[1];
  assign cnt_wr = wr_c_lo | wr_c_hi;
  assign presc_clr = cnt_wr | wr_a | wr_b;

  assign rd_mux = hit_a ? {24'h000000, ctrl_a_q} :
                  hit_b ? {24'h000000, run_q, dir_q == DIR_DOWN,
                           6'h00} :
                  hit_p ? {24'h000000, 1'b0, pin_en_q, pair_mode_bits_q} :
                  hit_t ? {24'h000000, sops_q, sdir_q, 1'b0, buffer_update_block_q,
                           override_sync_sel_q} :
                  hit_c ? {20'h00000, cnt_q} :
                  hit_r ? {20'h00000, per_buf_q} : 32'h00000000;

  // ---------------------------------------------------------------
  // Field views
  // ---------------------------------------------------------------
  logic [1:0] mode;
  logic [1:0] ckps;
  logic [3:0] ops;
  logic edge_mode;

  assign mode = ctrl_a_q[A_MOD_LSB +: 2];
  assign ckps = ctrl_a_q[A_CKPS_LSB +: 2];
  assign ops = ctrl_a_q[A_OPS_LSB +: 4];
  assign edge_mode = ~mode[1];

  // ---------------------------------------------------------------
  // Counter sequencing
  // ---------------------------------------------------------------
  logic tick, adv, at_top, at_zero, going_up, match_ev, zero_ev, per_load;
  logic [CNT_W-1:0] cnt_step, cnt_d;
  mpt_dir_t dir_d;

  mpt_prescaler u_presc (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(presc_clr),
    .sel_i(ckps),
    .tick_o(tick)
  );

  assign adv = run_q & tick;
  assign at_top = (cnt_q == per_act_q);
  assign at_zero = (cnt_q == '0);
  assign going_up = (dir_q == DIR_UP);
  assign match_ev = adv & at_top & going_up;
  assign zero_ev = adv & at_zero & ~going_up & ~edge_mode;

  assign cnt_step = edge_mode ? (at_top ? '0 : cnt_q + 1'b1) :
                    going_up ? (at_top ? (at_zero ? cnt_q : cnt_q - 1'b1)
                                       : cnt_q + 1'b1) :
                    (at_zero ? (at_top ? cnt_q : cnt_q + 1'b1)
                             : cnt_q - 1'b1);
  assign cnt_d = adv ? cnt_step : cnt_q;

  assign dir_d = edge_mode ? DIR_UP :
                 (going_up & adv & at_top) ? DIR_DOWN :
                 (~going_up & adv & at_zero) ? DIR_UP : dir_q;

  assign per_load = ~buffer_update_block_q & (~run_q | (edge_mode & match_ev) |
                    (~edge_mode & adv & at_zero));

  // ---------------------------------------------------------------
  // Postscalers and events
  // ---------------------------------------------------------------
  logic tb_src, post_hit, tb_ev_d, sev_qual, sev_hit, boundary, ovr_now;
  logic ovr_pend_d;

  assign tb_src = (mode == MODE_FREE) ? match_ev :
                  (mode == MODE_UPDN) ? zero_ev :
                  (mode == MODE_DOUBLE) ? (zero_ev | match_ev) : 1'b0;
  assign post_hit = tb_src & (post_q == ops);
  assign tb_ev_d = (mode == MODE_SINGLE) ? match_ev : post_hit;

  assign sev_qual = sev_match_i & ((dir_q == DIR_DOWN) == sdir_q);
  assign sev_hit = sev_qual & (sev_cnt_q == sops_q);

  assign boundary = adv & (edge_mode ? at_top : (at_zero & ~going_up));
  assign ovr_now = override_sync_sel_q ? (ovr_pend_q & boundary) :
                   (override_change_i | ovr_pend_q);
  assign ovr_pend_d = override_sync_sel_q & (override_change_i |
                                 (ovr_pend_q & ~ovr_now));

  // ---------------------------------------------------------------
  // Pin enable decode
  // ---------------------------------------------------------------
  logic [7:0] pins_dec;
  logic [7:0] pins_avail;

  assign pins_dec = (pin_en_q == 3'h0) ? PINS_NONE :
                    (pin_en_q == 3'h1) ? PINS_1 :
                    (pin_en_q == 3'h2) ? PINS_0_1 :
                    (pin_en_q == 3'h3) ? PINS_0_3 :
                    (pin_en_q == 3'h4) ? PINS_0_5 :
                    (pin_en_q == 3'h5) ? PINS_ALL :
                    (pin_en_q == 3'h6) ? PINS_1_3 : PINS_ODD;
  assign pins_avail = SMALL_VARIANT ? PINS_0_5 : PINS_ALL;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pair
      localparam bit PRESENT = !(SMALL_VARIANT && gi == 3);
      assign pair_indep_o[gi] = pair_mode_bits_q[gi] & PRESENT;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      dat_q <= (req & ~ack_q) ? rd_mux : dat_q;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_a_q <= CTRL_RST;
      sops_q <= NIB_RST;
      sdir_q <= 1'b0;
      buffer_update_block_q <= 1'b0;
      override_sync_sel_q <= 1'b0;
      pair_mode_bits_q <= NIB_RST;
    end else begin
      if (wr_a) begin
        ctrl_a_q <= wb_dat_i[7:0];
      end
      if (wr_t) begin
        sops_q <= wb_dat_i[T_SOPS_LSB +: 4];
        sdir_q <= wb_dat_i[T_SDIR_BIT];
        buffer_update_block_q <= wb_dat_i[T_BUFFER_UPDATE_BLOCK_BIT];
        override_sync_sel_q <= wb_dat_i[T_OVERRIDE_SYNC_SEL_BIT];
      end
      if (wr_p) begin
        pair_mode_bits_q <= wb_dat_i[3:0] & {~SMALL_VARIANT, 3'h7};
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_done_q <= 1'b0;
      pin_en_q <= PIN_EN_CFG_CLR;
      pins_q <= PINS_NONE;
    end else begin
      strap_done_q <= 1'b1;
      if (wr_p) begin
        pin_en_q <= wb_dat_i[P_EN_LSB +: 3];
      end else if (!strap_done_q) begin
        pin_en_q <= pin_default_cfg_i ? PIN_EN_CFG_SET
                                      : PIN_EN_CFG_CLR;
      end
      pins_q <= pins_dec & pins_avail;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_q <= 1'b0;
      dir_q <= DIR_UP;
      cnt_q <= '0;
    end else begin
      if (wr_b) begin
        run_q <= wb_dat_i[B_RUN_BIT];
      end else if (mode == MODE_SINGLE && match_ev) begin
        run_q <= 1'b0;
      end
      dir_q <= dir_d;
      cnt_q <= cnt_d;
      if (wr_c_lo) begin
        cnt_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_c_hi) begin
        cnt_q[CNT_W-1:8] <= wb_dat_i[CNT_W-1:8];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      per_buf_q <= PERIOD_RST;
      per_act_q <= PERIOD_RST;
    end else begin
      if (wr_r_lo) begin
        per_buf_q[7:0] <= wb_dat_i[7:0];
      end
      if (wr_r_hi) begin
        per_buf_q[CNT_W-1:8] <= wb_dat_i[CNT_W-1:8];
      end
      if (per_load) begin
        per_act_q <= per_buf_q;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      post_q <= NIB_RST;
      sev_cnt_q <= NIB_RST;
      tb_ev_q <= 1'b0;
      sev_q <= 1'b0;
      ovr_pend_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      if (presc_clr) begin
        post_q <= NIB_RST;
      end else if (tb_src) begin
        post_q <= post_hit ? NIB_RST : post_q + 4'h1;
      end
      if (wr_t) begin
        sev_cnt_q <= NIB_RST;
      end else if (sev_qual) begin
        sev_cnt_q <= sev_hit ? NIB_RST : sev_cnt_q + 4'h1;
      end
      tb_ev_q <= tb_ev_d;
      sev_q <= sev_hit;
      ovr_pend_q <= ovr_pend_d;
      ovr_q <= ovr_now;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign timebase_counter_o = cnt_q;
  assign count_down_flag_o = (dir_q == DIR_DOWN);
  assign center_aligned_o = mode[1];
  assign tb_event_o = tb_ev_q;
  assign sev_trig_o = sev_q;
  assign update_enable_o = ~buffer_update_block_q;
  assign override_apply_o = ovr_q;
  assign pin_enable_o = pins_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_shot_top;
    mode == MODE_SINGLE && match_ev && !wr_b && !cnt_wr;
  endsequence
  sequence s_shot_end;
    !run_q && cnt_q == '0;
  endsequence

  a_stop_hold: assert property (
    !run_q && !cnt_wr |=> cnt_q == $past(cnt_q))
    else $error("Counter moved while stopped.");
  a_shot_stop: assert property (s_shot_top |=> s_shot_end)
    else $error("Single-shot did not wrap and stop.");
  a_free_wrap: assert property (
    mode == MODE_FREE && match_ev && !cnt_wr && !wr_b
    |=> cnt_q == '0 && run_q)
    else $error("Free mode did not wrap.");
  a_turn_down: assert property (
    !edge_mode && match_ev && per_act_q != '0 && !cnt_wr
    |=> count_down_flag_o && cnt_q == $past(per_act_q) - 1'b1)
    else $error("Up/down did not turn at period.");
  a_dir_bits: assert property (
    wb_ack_o && hit_b |-> wb_dat_o[5:0] == 6'h00)
    else $error("Control B low bits not zero.");
  a_presc_clear: assert property (
    presc_clr |=> !tick [*3])
    else $error("Prescaler tick too soon after clear.");
  a_pin_decode: assert property (
    pin_en_q == 3'h2 |=> pin_enable_o == PINS_0_1)
    else $error("Pin enable decode wrong.");
  a_buffer_update_block_block: assert property (
    buffer_update_block_q && !wr_r_lo && !wr_r_hi |=> per_act_q == $past(per_act_q))
    else $error("Period loaded while updates blocked.");
  a_sev_dir: assert property (
    sev_trig_o |-> $past(sdir_q) == $past(count_down_flag_o))
    else $error("Trigger fired in wrong direction.");
  a_single_event: assert property (
    s_shot_top |=> tb_event_o)
    else $error("Single-shot match gave no event.");

endmodule

// [design/mpt_pkg.sv]
// Constants and types shared by the PWM time base and control block.
package mpt_pkg;

  localparam int CNT_W = 12;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_PINMODE = 8'h08;
  localparam logic [7:0] OFS_TRIG = 8'h0c;
  localparam logic [7:0] OFS_COUNTER = 8'h10;
  localparam logic [7:0] OFS_PERIOD = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int A_OPS_LSB = 4;
  localparam int A_CKPS_LSB = 2;
  localparam int A_MOD_LSB = 0;
  localparam int B_RUN_BIT = 7;
  localparam int B_DIR_BIT = 6;
  localparam int P_EN_LSB = 4;
  localparam int T_SOPS_LSB = 4;
  localparam int T_SDIR_BIT = 3;
  localparam int T_BUFFER_UPDATE_BLOCK_BIT = 1;
  localparam int T_OVERRIDE_SYNC_SEL_BIT = 0;

  // ---------------------------------------------------------------
  // Mode codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_UPDN = 2'h2;
  localparam logic [1:0] MODE_DOUBLE = 2'h3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [CNT_W-1:0] PERIOD_RST = 12'h000;
  localparam logic [2:0] PIN_EN_CFG_SET = 3'h7;
  localparam logic [2:0] PIN_EN_CFG_CLR = 3'h0;

  // ---------------------------------------------------------------
  // Prescaler terminal counts in core clocks (oscillator / n - 1)
  // ---------------------------------------------------------------
  localparam logic [7:0] PRE_LIM_4 = 8'h03;
  localparam logic [7:0] PRE_LIM_16 = 8'h0f;
  localparam logic [7:0] PRE_LIM_64 = 8'h3f;
  localparam logic [7:0] PRE_LIM_256 = 8'hff;

  // ---------------------------------------------------------------
  // Pin enable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] PINS_NONE = 8'h00;
  localparam logic [7:0] PINS_1 = 8'h02;
  localparam logic [7:0] PINS_0_1 = 8'h03;
  localparam logic [7:0] PINS_0_3 = 8'h0f;
  localparam logic [7:0] PINS_0_5 = 8'h3f;
  localparam logic [7:0] PINS_ALL = 8'hff;
  localparam logic [7:0] PINS_1_3 = 8'h0a;
  localparam logic [7:0] PINS_ODD = 8'haa;

  typedef enum logic {DIR_UP, DIR_DOWN} mpt_dir_t;

endpackage

// [design/mpt_prescaler.sv]
// Input clock prescaler producing a one-cycle time base tick.
`timescale 1ns/1ps
module mpt_prescaler
  import mpt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  input wire logic [1:0] sel_i,
  output logic tick_o
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] lim;

  assign lim = (sel_i == 2'h0) ? PRE_LIM_4 :
               (sel_i == 2'h1) ? PRE_LIM_16 :
               (sel_i == 2'h2) ? PRE_LIM_64 : PRE_LIM_256;
  assign tick_o = ~clr_i & (cnt_q == lim);
  assign cnt_d = (clr_i | tick_o) ? 8'h00 : cnt_q + 8'h01;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// [dv/mpt_switch_model.sv]
// Load model for the power switching stages hanging on the PWM pins.
`timescale 1ns/1ps
module mpt_switch_model (
  input wire logic core_clk_i,
  input wire logic [7:0] pin_enable_i,
  input wire logic [3:0] pair_indep_i,
  output logic [3:0] stage_count_o,
  output logic [3:0] indep_pairs_o
);
  // Each enabled pin drives one switch stage; the count is registered.
  always_ff @(posedge core_clk_i) begin
    stage_count_o <= 4'($countones(pin_enable_i));
    indep_pairs_o <= pair_indep_i;
  end
endmodule

// [dv/tb_motor_pwm_time_base_control.sv]
// Self-checking testbench for the PWM time base and control block.
`timescale 1ns/1ps
module tb_motor_pwm_time_base_control;
  import mpt_pkg::*;
  logic core_clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, pin_enable_o, pins_small;
  logic [3:0] wb_sel_i, pair_indep_o, stage_count, indep_pairs, pairs_small;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic pin_default_cfg_i, sev_match_i, override_change_i;
  logic [CNT_W-1:0] timebase_counter_o;
  logic count_down_flag_o, center_aligned_o, tb_event_o, sev_trig_o;
  logic update_enable_o, override_apply_o;
  int fail_count = 0;
  int samples_checked = 0;

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  mpt_timebase #(.SMALL_VARIANT(1'b0)) i_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pin_default_cfg_i(pin_default_cfg_i),
    .sev_match_i(sev_match_i), .override_change_i(override_change_i),
    .timebase_counter_o(timebase_counter_o),
    .count_down_flag_o(count_down_flag_o),
    .center_aligned_o(center_aligned_o), .tb_event_o(tb_event_o),
    .sev_trig_o(sev_trig_o), .update_enable_o(update_enable_o),
    .override_apply_o(override_apply_o), .pin_enable_o(pin_enable_o),
    .pair_indep_o(pair_indep_o));

  mpt_switch_model i_load (.core_clk_i(core_clk_i),
    .pin_enable_i(pin_enable_o), .pair_indep_i(pair_indep_o),
    .stage_count_o(stage_count), .indep_pairs_o(indep_pairs));

  mpt_timebase #(.SMALL_VARIANT(1'b1)) i_dut_small (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(),
    .pin_default_cfg_i(pin_default_cfg_i), .sev_match_i(sev_match_i),
    .override_change_i(override_change_i), .timebase_counter_o(),
    .count_down_flag_o(), .center_aligned_o(), .tb_event_o(),
    .sev_trig_o(), .update_enable_o(), .override_apply_o(),
    .pin_enable_o(pins_small), .pair_indep_o(pairs_small));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic [31:0] d,
                      input logic w, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h0, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, d, 1'b1, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] q;
    xfer(a, 32'h0, 1'b0, q);
    chk(nm, q, exp);
  endtask

  task automatic wait_evt(output int n);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (tb_event_o !== 1'b1 && n < 2000);
    if (n >= 2000) chk("evt_wait", 32'h0, 32'h1);
  endtask

  task automatic wait_dir(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (count_down_flag_o !== v && n < 500);
    if (n >= 500) chk("dir_wait", 32'h0, 32'h1);
  endtask

  task automatic pulse(input bit ovr, output logic seen);
    if (ovr) override_change_i <= 1'b1;
    else sev_match_i <= 1'b1;
    @(posedge core_clk_i);
    override_change_i <= 1'b0;
    sev_match_i <= 1'b0;
    @(posedge core_clk_i);
    seen = ovr ? override_apply_o : sev_trig_o;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd_chk("ctrl_a", OFS_CTRL_A, 32'h0);
    rd_chk("ctrl_b", OFS_CTRL_B, 32'h0);
    rd_chk("pinmode", OFS_PINMODE, 32'h70);
    rd_chk("trig", OFS_TRIG, 32'h0);
    chk("pins_rst", pin_enable_o, 32'haa);
  endtask

  task automatic t_pins();
    logic [7:0] exp [8] = '{8'h00, 8'h02, 8'h03, 8'h0f, 8'h3f, 8'hff,
                            8'h0a, 8'haa};
    for (int c = 0; c < 8; c++) begin
      wr(OFS_PINMODE, 32'(c << 4) | 32'h5);
      repeat (3) @(posedge core_clk_i);
      chk("pins", pin_enable_o, exp[c]);
      chk("stages", stage_count, $countones(exp[c]));
      chk("pins_small", pins_small, exp[c] & 8'h3f);
    end
    chk("pairs", pair_indep_o, 32'h5);
    chk("indep", indep_pairs, 32'h5);
    chk("pairs_small", pairs_small, 32'h5);
  endtask

  task automatic t_rate(input logic [1:0] ck, input logic [3:0] ops,
                        input int exp);
    int n;
    wr(OFS_PERIOD, 32'h3);
    wr(OFS_CTRL_A, {24'h0, ops, ck, MODE_FREE});
    wr(OFS_CTRL_B, 32'h80);
    wait_evt(n);
    wait_evt(n);
    chk("evt_gap", n, exp);
    chk("cnt_wrap", timebase_counter_o, 32'h0);
    chk("edge_mode", center_aligned_o, 32'h0);
    wr(OFS_CTRL_B, 32'h0);
  endtask

  task automatic t_hold();
    logic [31:0] c1, c2;
    wr(OFS_PERIOD, 32'hfff);
    wr(OFS_CTRL_B, 32'h80);
    repeat (100) @(posedge core_clk_i);
    wr(OFS_CTRL_B, 32'h0);
    xfer(OFS_COUNTER, 32'h0, 1'b0, c1);
    repeat (40) @(posedge core_clk_i);
    xfer(OFS_COUNTER, 32'h0, 1'b0, c2);
    chk("ran", c1 != 0, 32'h1);
    chk("held", c2, c1);
  endtask

  task automatic t_single();
    int n;
    wr(OFS_COUNTER, 32'h0);
    wr(OFS_PERIOD, 32'h2);
    wr(OFS_CTRL_A, {24'h0, 4'h3, 2'h0, MODE_SINGLE});
    wr(OFS_CTRL_B, 32'h80);
    wait_evt(n);
    chk("one_shot_fast", n < 30, 32'h1);
    repeat (20) @(posedge core_clk_i);
    rd_chk("run_cleared", OFS_CTRL_B, 32'h0);
    chk("shot_cnt", timebase_counter_o, 32'h0);
  endtask

  task automatic t_updown();
    logic s;
    logic [CNT_W-1:0] c1;
    int n;
    wr(OFS_PERIOD, 32'h8);
    wr(OFS_TRIG, 32'h08);
    wr(OFS_CTRL_A, {24'h0, 4'h0, 2'h0, MODE_UPDN});
    wr(OFS_CTRL_B, 32'h80);
    chk("centre", center_aligned_o, 32'h1);
    wait_dir(1'b1);
    pulse(1'b0, s);
    chk("sev_down", s, 32'h1);
    rd_chk("dir_bit", OFS_CTRL_B, 32'hc0);
    c1 = timebase_counter_o;
    repeat (4) @(posedge core_clk_i);
    chk("counts_down", timebase_counter_o < c1, 32'h1);
    wait_dir(1'b0);
    pulse(1'b0, s);
    chk("sev_up", s, 32'h0);
    wr(OFS_TRIG, 32'h18);
    wait_dir(1'b1);
    pulse(1'b0, s);
    chk("sev_post1", s, 32'h0);
    pulse(1'b0, s);
    chk("sev_post2", s, 32'h1);
    wait_evt(n);
    wait_evt(n);
    chk("updn_gap", n, 64);
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_CTRL_A, {24'h0, 4'h0, 2'h0, MODE_DOUBLE});
    repeat (2) @(posedge core_clk_i);
    chk("centre_dbl", center_aligned_o, 32'h1);
    wr(OFS_CTRL_B, 32'h80);
    wait_evt(n);
    wait_evt(n);
    chk("dbl_gap", n, 32);
    wr(OFS_CTRL_B, 32'h0);
  endtask

  task automatic t_misc();
    logic s;
    int n;
    wr(OFS_TRIG, 32'h02);
    wr(OFS_PERIOD, 32'h5);
    repeat (2) @(posedge core_clk_i);
    chk("upd_blocked", update_enable_o, 32'h0);
    wr(OFS_TRIG, 32'h00);
    repeat (2) @(posedge core_clk_i);
    chk("upd_open", update_enable_o, 32'h1);
    pulse(1'b1, s);
    chk("ovr_async", s, 32'h1);
    @(posedge core_clk_i);
    chk("ovr_once", override_apply_o, 32'h0);
    wr(OFS_TRIG, 32'h01);
    pulse(1'b1, s);
    chk("ovr_sync", s, 32'h0);
    wr(OFS_COUNTER, 32'h0);
    wr(OFS_CTRL_B, 32'h80);
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (override_apply_o !== 1'b1 && n < 200);
    chk("ovr_synced", n < 200, 32'h1);
    rd_chk("unmapped", 8'h3c, 32'h0);
  endtask

  task automatic t_strap();
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    pin_default_cfg_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rd_chk("strap0", OFS_PINMODE, 32'h0);
    chk("pins_strap0", pin_enable_o, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    pin_default_cfg_i = 1'b1;
    sev_match_i = 1'b0;
    override_change_i = 1'b0;
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    t_reset();
    t_pins();
    t_rate(2'h0, 4'h0, 16);
    t_rate(2'h1, 4'h0, 64);
    t_rate(2'h0, 4'h2, 48);
    t_rate(2'h0, 4'hf, 256);
    t_hold();
    t_single();
    t_updown();
    t_misc();
    t_strap();
    final_report();
  end

  initial begin
    repeat (40000) @(posedge core_clk_i);
    fail_count++;
    final_report();
  end
endmodule
